// ---- sim/pin_one_source.sv ----
`default_nettype none
module pin_one_source (
  input  wire logic       pclk,
  input  wire logic [2:0] want_func,
  input  wire logic       want_level,
  output var  logic [2:0] pin_one_function,
  output var  logic       pin_one_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // designation and level of pin one, launched after the clock edge
  always @(posedge pclk) begin
    pin_one_function <= want_func;
    pin_one_in       <= want_level;
  end
endmodule
`default_nettype wire

// ---- sim/runtime_settings_update_decoder_assertions.sv ----
`default_nettype none
module runtime_settings_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic [2:0]  pin_one_function,
  input wire logic [1:0]  adc_reference_level,
  input wire logic        adc_reference_internal,
  input wire logic        interrupt_flag,
  input wire logic        pin_zero_out,
  input wire logic        pin_zero_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wr_age;
  // cycles since the last completed write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) wr_age <= 4'hf;
    else if (psel && penable && pready && pwrite) wr_age <= 4'h0;
    else if (wr_age != 4'hf) wr_age <= wr_age + 4'h1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_access: assert property (psel && penable |-> ##[0:1] pready) else $error("no ready");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("read data idle");
  a_level_cause: assert property ($changed(adc_reference_level) |-> wr_age <= 4'h8) else $error("level moved");
  a_source_cause: assert property ($changed(adc_reference_internal) |-> wr_age <= 4'h8) else $error("source moved");
  a_flag_clear_cause: assert property ($fell(interrupt_flag) |-> wr_age <= 4'h8) else $error("flag dropped");
  a_flag_needs_func: assert property ($rose(interrupt_flag) |-> pin_one_function == 3'h4) else $error("flag rose");
  a_pin_released_low: assert property (pin_zero_oe_n |-> !pin_zero_out) else $error("pin undriven high");
  a_pin_cause: assert property ($changed(pin_zero_oe_n) |-> wr_age <= 4'h9) else $error("pin enable moved");
  c_flag_set: cover property ($rose(interrupt_flag));
  c_level_high: cover property (adc_reference_level == 2'h3);
  c_pin_driven: cover property (!pin_zero_oe_n);
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
`default_nettype none
`include "runtime_settings_regs.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sus, rxl, lvl_w, irq;
  logic [5:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [32:0] e, exp_rd;
  logic [3:0] strb;
  logic [2:0] p1f, f_w, func;
  logic p1, src, rise, fall, flag, val, dir, flag_o, pz, pz_oe_n, internal;
  logic [1:0] lvl, adc_lvl;
  logic [32:0] q[$];
  int mismatches, n_checks;
  runtime_settings_update_decoder uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pin_one_in(p1), .pin_one_function(p1f), .suspend_indicator(sus),
    .rx_activity_led(rxl), .adc_reference_level(adc_lvl), .adc_reference_internal(internal),
    .interrupt_flag(flag_o), .pin_zero_out(pz), .pin_zero_oe_n(pz_oe_n), .irq(irq));
  pin_one_source far (.pclk(pclk), .want_func(f_w), .want_level(lvl_w), .pin_one_function(p1f), .pin_one_in(p1));
  initial begin pclk = 0; forever #2 pclk = ~pclk; end
  task automatic finish_test;
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] x);
    q.push_back({(a > `OFS_IRQ_MASK) || (a[1:0] != 2'h0), x});
    apb(0, a, 32'h0);
  endtask
  function automatic logic [31:0] sets();
    return {13'h0, f_w, 3'h0, func, dir, val, 1'b0, flag, fall, rise, 1'b0, lvl, src};
  endfunction
  task automatic cmd(input logic [7:0] c0, b5, b6, b7, b8);
    apb(1, `OFS_CMD_LO, {24'h0, c0});
    apb(1, `OFS_CMD_HI, {b7, b6, b5, 8'h0});
    apb(1, `OFS_CMD_PIN, {24'h0, b8});
    apb(1, `OFS_CTRL, 32'h1);
    repeat (6) @(posedge pclk);
    if (c0 == `CMD_SET_SETTINGS) begin
      if (b5[7]) {lvl, src} = b5[2:0];
      if (b6[7] && b6[4]) rise = b6[3];
      if (b6[7] && b6[2]) fall = b6[1];
      if (b6[7] && b6[0]) flag = 0;
      if (b7[7]) begin val = b8[4]; dir = b8[3]; if (b8[2:0] < 3'h3) func = b8[2:0]; end
    end
  endtask
  always @(posedge pclk) if (psel && penable && pready === 1'b1 && !pwrite) begin
    exp_rd = q.pop_front();
    `CHK({pslverr, prdata}, exp_rd)
  end
  initial begin #200000; mismatches++; finish_test(); end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, lvl_w, f_w} = 0;
    {lvl, src, rise, fall, flag, val, func} = 0;
    dir = 1; sus = 0; rxl = 0; presetn = 0; strb = 4'hf;
    void'($urandom(32'h3614));
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(`OFS_SETTINGS, sets());
    rd(6'h20, 32'h0);
    for (int i = 0; i < 14; i++) begin
      f_w <= 3'($urandom); sus <= 1'($urandom); rxl <= 1'($urandom);
      cmd(8'h60, 8'($urandom), 8'($urandom) & 8'hfe, 8'($urandom), 8'($urandom));
      rd(`OFS_SETTINGS, sets());
      rd(`OFS_RESPONSE, 32'h60);
      `CHK({adc_lvl, internal}, {lvl, src})
      e = (func == 0) ? {dir, val & !dir} : {1'b0, (func == 1) ? sus : rxl};
      `CHK({pz_oe_n, pz}, e[1:0])
    end
    apb(1, `OFS_IRQ_STATUS, 32'h7);
    apb(1, `OFS_IRQ_MASK, 32'h2);
    cmd(8'h61, 8'h87, 8'h9f, 8'h80, 8'h18);
    rd(`OFS_SETTINGS, sets());
    `CHK(irq, 1'b1)
    apb(1, `OFS_IRQ_STATUS, 32'h7);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    f_w <= 3'h4;
    cmd(8'h60, 8'h00, 8'h9d, 8'h00, 8'h00);
    lvl_w <= 1;
    repeat (10) @(posedge pclk);
    flag = 1;
    rd(`OFS_SETTINGS, sets());
    `CHK(flag_o, flag)
    lvl_w <= 0;
    cmd(8'h60, 8'h00, 8'h01, 8'h00, 8'h00);
    rd(`OFS_SETTINGS, sets());
    cmd(8'h60, 8'h00, 8'h81, 8'h00, 8'h00);
    rd(`OFS_SETTINGS, sets());
    `CHK(flag_o, flag)
    strb <= 4'h2;
    apb(1, `OFS_CMD_HI, 32'hffff_ffff);
    strb <= 4'hf;
    rd(`OFS_CMD_HI, 32'h0081_ff00);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    {lvl, src, rise, fall, flag, val, func} = 0;
    dir = 1;
    rd(`OFS_SETTINGS, sets());
    `CHK({pz_oe_n, irq}, 2'b10)
    finish_test();
  end
endmodule
bind runtime_settings_update_decoder runtime_settings_checker chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .prdata(prdata),
  .pin_one_function(pin_one_function), .adc_reference_level(adc_reference_level),
  .adc_reference_internal(adc_reference_internal), .interrupt_flag(interrupt_flag),
  .pin_zero_out(pin_zero_out), .pin_zero_oe_n(pin_zero_oe_n));
`default_nettype wire

// ---- src/pin_one_edge_detector.v ----
`default_nettype none
module pin_one_edge_detector (
  input  wire pclk,
  input  wire presetn,
  input  wire pin_in,
  input  wire active,
  input  wire rise_enable,
  input  wire fall_enable,
  input  wire clear,
  output reg  flag,
  output reg  edge_seen
);
  reg sync_a;
  reg sync_b;
  reg last;
  wire next_edge;

  assign next_edge = active & ((rise_enable & sync_b & ~last) | (fall_enable & ~sync_b & last));

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a    <= 1'b0;
      sync_b    <= 1'b0;
      last      <= 1'b0;
      flag      <= 1'b0;
      edge_seen <= 1'b0;
    end else begin
      sync_a    <= pin_in;
      sync_b    <= sync_a;
      last      <= sync_b;
      edge_seen <= next_edge;
      if (next_edge) begin
        flag <= 1'b1;
      end else if (clear) begin
        flag <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- src/pin_zero_driver.v ----
`default_nettype none
`include "runtime_settings_regs.vh"
module pin_zero_driver (
  input  wire       pclk,
  input  wire       presetn,
  input  wire [2:0] function_code,
  input  wire       direction_in,
  input  wire       gpio_value,
  input  wire       suspend_indicator,
  input  wire       rx_activity_led,
  output reg        pin_out,
  output reg        pin_oe_n
);
  reg next_out;
  reg next_oe_n;

  always @* begin
    next_out  = 1'b0;
    next_oe_n = 1'b1;
    case (function_code)
      `FUNC_GPIO: begin
        next_out  = gpio_value & ~direction_in;
        next_oe_n = direction_in;
      end
      `FUNC_SUSPEND: begin
        next_out  = suspend_indicator;
        next_oe_n = 1'b0;
      end
      `FUNC_RX_LED: begin
        next_out  = rx_activity_led;
        next_oe_n = 1'b0;
      end
      default: begin
        next_out  = 1'b0;
        next_oe_n = 1'b1;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out  <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      pin_out  <= next_out;
      pin_oe_n <= next_oe_n;
    end
  end
endmodule
`default_nettype wire

// ---- src/runtime_settings_regs.vh ----
// Contract
// - byte5 bit7 loads adc reference bits 2-0
// - byte5 bits 2-1 pick reference level
// - byte5 bit0 internal module or supply
// - byte6 bit7 gates all detector changes
// - byte6 bit4 loads rising enable from bit3
// - byte6 bit2 loads falling enable from bit1
// - byte6 bit0 clears interrupt detection flag
// - byte7 bit7 loads pin settings from byte8
// - byte8 bit4 is pin_zero output level
// - byte8 bit3 direction, only for gpio
// - byte8 bits 2-0 select pin_zero function
// - don't care bits affect nothing
// - byte0 0x60 marks settings update command
// - settings volatile, reset restores defaults
// - response echoes 0x60 then 0x00
// - detector watches pin_one, code 100 only
`ifndef RUNTIME_SETTINGS_REGS_VH
`define RUNTIME_SETTINGS_REGS_VH

// apb byte offsets
`define OFS_CMD_LO       6'h00
`define OFS_CMD_HI       6'h04
`define OFS_CMD_PIN      6'h08
`define OFS_CTRL         6'h0c
`define OFS_RESPONSE     6'h10
`define OFS_SETTINGS     6'h14
`define OFS_IRQ_STATUS   6'h18
`define OFS_IRQ_MASK     6'h1c

// command codes
`define CMD_SET_SETTINGS 8'h60
`define RESP_SUCCESS     8'h00

// command byte field positions
`define LOAD_BIT         7
`define ADC_SRC_BIT      0
`define INT_RISE_LOAD    4
`define INT_RISE_VAL     3
`define INT_FALL_LOAD    2
`define INT_FALL_VAL     1
`define INT_CLEAR_BIT    0
`define PIN_VALUE_BIT    4
`define PIN_DIR_BIT      3

// pin function codes
`define FUNC_GPIO        3'h0
`define FUNC_SUSPEND     3'h1
`define FUNC_RX_LED      3'h2
`define FUNC_PIN_ONE_INT 3'h4

// power-up defaults
`define RST_ADC_REF      3'h0
`define RST_RISE_EN      1'b0
`define RST_FALL_EN      1'b0
`define RST_PIN_VALUE    1'b0
`define RST_PIN_DIR      1'b1
`define RST_PIN_FUNC     3'h0

// interrupt status bits
`define IRQ_DONE         0
`define IRQ_REJECT       1
`define IRQ_EDGE         2
`define IRQ_WIDTH        3

`endif

// ---- src/runtime_settings_update_decoder.v ----
`default_nettype none
`include "runtime_settings_regs.vh"
module runtime_settings_update_decoder (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [5:0]  paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  input  wire        pin_one_in,
  input  wire [2:0]  pin_one_function,
  input  wire        suspend_indicator,
  input  wire        rx_activity_led,
  output reg  [1:0]  adc_reference_level,
  output reg         adc_reference_internal,
  output wire        interrupt_flag,
  output wire        pin_zero_out,
  output wire        pin_zero_oe_n,
  output reg         irq
);
  // states of the command sequencer
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_CHECK = 3'b010;
  localparam [2:0] ST_APPLY = 3'b100;
  // power-up reference word, level in [2:1], source in [0]
  localparam [2:0] RST_REF  = `RST_ADC_REF;

  reg  [2:0]  state;
  reg  [2:0]  next_state;

  // command bytes as written by software, response bytes set by the sequencer
  reg  [31:0] cmd_lo;
  reg  [31:0] cmd_hi;
  reg  [7:0]  cmd_pin;
  reg  [7:0]  resp_code;
  reg  [7:0]  resp_status;

  // run-time settings
  reg         rise_enable;
  reg         fall_enable;
  reg         pin_value;
  reg         pin_direction;
  reg  [2:0]  pin_function;

  reg  [`IRQ_WIDTH-1:0] irq_status;
  reg  [`IRQ_WIDTH-1:0] irq_mask;

  wire [7:0]  byte0;
  wire [7:0]  byte5;
  wire [7:0]  byte6;
  wire [7:0]  byte7;
  wire        access;
  wire        wr_done;
  wire        rd_start;
  wire        exec_req;
  wire        apply;
  wire        int_update;
  wire        clear_flag;
  wire        edge_seen;
  wire        is_command;
  reg  [31:0] next_rdata;
  reg         next_slverr;
  reg  [`IRQ_WIDTH-1:0] irq_set;

  assign byte0 = cmd_lo[7:0];
  assign byte5 = cmd_hi[15:8];
  assign byte6 = cmd_hi[23:16];
  assign byte7 = cmd_hi[31:24];

  assign access   = psel & penable;
  assign wr_done  = access & pready & pwrite;
  assign rd_start = access & ~pready;
  assign exec_req = wr_done & (paddr == `OFS_CTRL) & pstrb[0] & pwdata[0];
  assign apply    = (state == ST_APPLY);

  assign is_command = (byte0 == `CMD_SET_SETTINGS);

  // byte lane merge for partial writes
  function [31:0] merge_lanes;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0]  strobes;
    integer i;
    begin
      merge_lanes = old_word;
      for (i = 0; i < 4; i = i + 1) begin
        if (strobes[i]) begin
          merge_lanes[i*8 +: 8] = new_word[i*8 +: 8];
        end
      end
    end
  endfunction

  // known register decode
  function is_mapped;
    input [5:0] addr;
    begin
      case (addr)
        `OFS_CMD_LO, `OFS_CMD_HI, `OFS_CMD_PIN, `OFS_CTRL,
        `OFS_RESPONSE, `OFS_SETTINGS, `OFS_IRQ_STATUS, `OFS_IRQ_MASK: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  // apb handshake: one wait state per transfer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= rd_start;
      prdata  <= rd_start ? next_rdata : 32'h0000_0000;
      pslverr <= rd_start & next_slverr;
    end
  end

  always @* begin
    next_rdata  = 32'h0000_0000;
    next_slverr = ~is_mapped(paddr);
    if (!pwrite) begin
      case (paddr)
        `OFS_CMD_LO:     next_rdata = cmd_lo;
        `OFS_CMD_HI:     next_rdata = cmd_hi;
        `OFS_CMD_PIN:    next_rdata = {24'h000000, cmd_pin};
        `OFS_CTRL:       next_rdata = {31'h00000000, ~state[0]};
        `OFS_RESPONSE:   next_rdata = {16'h0000, resp_status, resp_code};
        `OFS_SETTINGS:   next_rdata = {13'h0000, pin_one_function, 3'h0, pin_function,
                                        pin_direction, pin_value, 1'b0,
                                        interrupt_flag, fall_enable, rise_enable, 1'b0,
                                        adc_reference_level, adc_reference_internal};
        `OFS_IRQ_STATUS: next_rdata = {29'h00000000, irq_status};
        `OFS_IRQ_MASK:   next_rdata = {29'h00000000, irq_mask};
        default:         next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // command byte storage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_lo  <= 32'h0000_0000;
      cmd_hi  <= 32'h0000_0000;
      cmd_pin <= 8'h00;
    end else if (wr_done) begin
      if (paddr == `OFS_CMD_LO) begin
        cmd_lo <= merge_lanes(cmd_lo, pwdata, pstrb);
      end
      if (paddr == `OFS_CMD_HI) begin
        cmd_hi <= merge_lanes(cmd_hi, pwdata, pstrb);
      end
      if ((paddr == `OFS_CMD_PIN) && pstrb[0]) begin
        cmd_pin <= pwdata[7:0];
      end
    end
  end

  // command sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE:  next_state = exec_req ? ST_CHECK : ST_IDLE;
      ST_CHECK: next_state = is_command ? ST_APPLY : ST_IDLE;
      ST_APPLY: next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // response after completion
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_code   <= 8'h00;
      resp_status <= 8'h00;
    end else if (apply) begin
      resp_code   <= `CMD_SET_SETTINGS;
      resp_status <= `RESP_SUCCESS;
    end
  end

  // adc reference, unused byte 5 bits never read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_reference_level    <= RST_REF[2:1];
      adc_reference_internal <= RST_REF[0];
    end else if (apply && byte5[`LOAD_BIT]) begin
      adc_reference_level    <= byte5[2:1];
      adc_reference_internal <= byte5[`ADC_SRC_BIT];
    end
  end

  // edge detector settings
  assign int_update = apply & byte6[`LOAD_BIT];
  assign clear_flag = int_update & byte6[`INT_CLEAR_BIT];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_enable <= `RST_RISE_EN;
      fall_enable <= `RST_FALL_EN;
    end else if (int_update) begin
      if (byte6[`INT_RISE_LOAD]) begin
        rise_enable <= byte6[`INT_RISE_VAL];
      end
      if (byte6[`INT_FALL_LOAD]) begin
        fall_enable <= byte6[`INT_FALL_VAL];
      end
    end
  end

  // pin zero designation
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_value     <= `RST_PIN_VALUE;
      pin_direction <= `RST_PIN_DIR;
      pin_function  <= `RST_PIN_FUNC;
    end else if (apply && byte7[`LOAD_BIT]) begin
      pin_value     <= cmd_pin[`PIN_VALUE_BIT];
      pin_direction <= cmd_pin[`PIN_DIR_BIT];
      if (cmd_pin[2:0] == `FUNC_GPIO || cmd_pin[2:0] == `FUNC_SUSPEND ||
          cmd_pin[2:0] == `FUNC_RX_LED) begin
        pin_function <= cmd_pin[2:0];
      end
    end
  end

  pin_one_edge_detector u_edge (
    .pclk        (pclk),
    .presetn     (presetn),
    .pin_in      (pin_one_in),
    .active      (pin_one_function == `FUNC_PIN_ONE_INT),
    .rise_enable (rise_enable),
    .fall_enable (fall_enable),
    .clear       (clear_flag),
    .flag        (interrupt_flag),
    .edge_seen   (edge_seen)
  );

  pin_zero_driver u_pin_zero (
    .pclk              (pclk),
    .presetn           (presetn),
    .function_code     (pin_function),
    .direction_in      (pin_direction),
    .gpio_value        (pin_value),
    .suspend_indicator (suspend_indicator),
    .rx_activity_led   (rx_activity_led),
    .pin_out           (pin_zero_out),
    .pin_oe_n          (pin_zero_oe_n)
  );

  // interrupt status: set wins over write-one clear
  always @* begin
    irq_set                = {`IRQ_WIDTH{1'b0}};
    irq_set[`IRQ_DONE]     = apply;
    irq_set[`IRQ_REJECT]   = (state == ST_CHECK) & ~is_command;
    irq_set[`IRQ_EDGE]     = edge_seen;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= {`IRQ_WIDTH{1'b0}};
      irq_mask   <= {`IRQ_WIDTH{1'b0}};
      irq        <= 1'b0;
    end else begin
      if (wr_done && (paddr == `OFS_IRQ_STATUS) && pstrb[0]) begin
        irq_status <= (irq_status & ~pwdata[`IRQ_WIDTH-1:0]) | irq_set;
      end else begin
        irq_status <= irq_status | irq_set;
      end
      if (wr_done && (paddr == `OFS_IRQ_MASK) && pstrb[0]) begin
        irq_mask <= pwdata[`IRQ_WIDTH-1:0];
      end
      irq <= |(irq_status & irq_mask);
    end
  end
endmodule
`default_nettype wire
